// File: dv/dsra_host.sv
// Host model issuing one register request per call
`timescale 1ns/1ps
module dsra_host (
  input  wire        clk,
  input  wire        resp_valid, resp_exception,
  input  wire [7:0]  resp_exc_code,
  input  wire [15:0] resp_data,
  output reg         req_valid, req_write,
  output reg  [15:0] req_start, req_count, req_index
);
  initial {req_valid, req_write, req_start, req_count, req_index} = 0;
  // Answer is read mid-cycle so it never races the registering edge
  task xfer(input w, input [15:0] s, c, i, output [25:0] r);
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_start <= s;
    req_count <= c;
    req_index <= i;
    @(posedge clk);
    req_valid <= 1'b0;
    req_start <= ~s; // Released address no longer shows the old value
    @(negedge clk);
    r = {resp_valid, resp_exception, resp_exc_code, resp_data};
  endtask
endmodule // dsra_host

// File: dv/dsra_status_bank_properties.sv
// Checker of status bank answer timing and fields
`timescale 1ns/1ps
module dsra_props #(parameter MAX_REGS = 16) (
  input wire        clk, reset_n, req_valid, req_write, resp_valid, resp_exception,
  input wire [15:0] req_start, req_count, req_index, resp_data,
  input wire [7:0]  resp_exc_code, event_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_rd(a, n);
    req_valid && !req_write && req_start == a && req_count == n && req_index == 0;
  endsequence
  answer_delay_a: assert property (req_valid |=> resp_valid)
    else $error("answer missing");
  answer_pulse_a: assert property (!req_valid |=> !resp_valid)
    else $error("answer without request");
  write_refused_a: assert property (req_valid && req_write |=> resp_exc_code == 8'h01)
    else $error("write not refused");
  odd_count_a: assert property (req_valid && !req_write && req_start[15] && req_count[0]
    |=> resp_exception && resp_exc_code == 8'h03) else $error("odd count taken");
  count_zero_a: assert property (req_valid && !req_write && req_count == 0
    |=> resp_exception && resp_exc_code == 8'h03) else $error("zero count taken");
  wide_high_a: assert property (s_rd(16'he500, 2) |=> !resp_exception && resp_data == 0)
    else $error("bad high half");
  state_code_a: assert property (s_rd(16'h6500, 1) ##0 $past(reset_n)
    |=> resp_data[15:7] == {$past(event_code, 2), 1'b0}) else $error("bad event code");
  addr_range_a: assert property (s_rd(16'h6529, 1) |=> resp_exc_code == 8'h02)
    else $error("address not refused");
  type_reserved_a: assert property (s_rd(16'h651f, 1) |=> resp_data[15:7] == 0)
    else $error("reserved bits set");
  phase_reserved_a: assert property (s_rd(16'h6528, 1) |=> resp_data[1:0] == 0)
    else $error("reserved phase bits set");
endmodule // dsra_props
bind dsra_status_bank dsra_props #(.MAX_REGS(MAX_REGS)) u_props (.*);

// File: dv/tb_drive_status_register_access.sv
// Self-checking bench for the drive status register bank
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb_drive_status_register_access;
  reg clk = 0, reset_n = 0, serial_ctrl_en = 1, running = 0, reverse = 1, serial_ref_en = 0;
  reg main_set_reached = 1, fault_present = 1, alarm_present = 0, under_voltage = 1;
  reg drive_fault = 1;
  reg [7:0] event_code = 8'ha5;
  reg [5:0] run_type = 6'h2a, motion_phase = 6'h15;
  reg [3:0] limiting = 4'h9, family_digits = 4'h1;
  reg [2:0] control_mode = 3'h5;
  reg [6:0] series_digits = 7'h1e;
  reg [31:0] main_ref_value = 32'h1234_5678, run_freq_value = 32'h0001_86a0;
  reg [31:0] set_freq_value = 32'h0000_0bb8, fault3_freq_value = 32'hffe7_9600;
  wire resp_valid, resp_exception, req_valid, req_write;
  wire [7:0] resp_exc_code;
  wire [15:0] resp_data, req_start, req_count, req_index;
  integer failures = 0, checks = 0;
  reg [25:0] r;
  always #50 clk = ~clk;
  dsra_status_bank u_dut (.*);
  dsra_host u_host (.*);
  task chk(input w, input [15:0] s, c, i, input [7:0] e, input [15:0] d);
    u_host.xfer(w, s, c, i, r);
    `CHK("answer", {1'b1, e != 8'h00}, r[25:24])
    `CHK("code", e, r[23:16])
    `CHK("data", d, r[15:0])
    $display("test %h done", s);
  endtask
  task stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    stop_test;
  end
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    chk(0, 16'h6500, 1, 0, 0, 16'ha535);
    chk(0, 16'h651f, 1, 0, 0, 16'h006a);
    chk(0, 16'h6528, 1, 0, 0, 16'hb954);
    chk(0, 16'h6502, 1, 0, 0, 16'h0082);
    chk(0, 16'he505, 2, 0, 0, 16'h0001);
    chk(0, 16'he505, 2, 1, 0, 16'h86a0);
    chk(0, 16'h6505, 1, 0, 0, 16'h86a0);
    chk(0, 16'he501, 4, 0, 0, 16'h1234);
    chk(0, 16'h6515, 1, 0, 0, 16'h0bb8);
    chk(0, 16'he525, 2, 1, 0, 16'h9600);
    chk(0, 16'he500, 2, 0, 0, 16'h0000);
    chk(0, 16'he505, 3, 0, 8'h03, 0);
    chk(0, 16'h6500, 0, 0, 8'h03, 0);
    chk(0, 16'h6500, 17, 0, 8'h03, 0);
    chk(1, 16'h6500, 1, 0, 8'h01, 0);
    chk(0, 16'h6529, 1, 0, 8'h02, 0);
    @(posedge clk);
    running <= 1'b1;
    fault_present <= 1'b0;
    alarm_present <= 1'b1;
    event_code <= 8'h3c;
    chk(0, 16'h6500, 1, 0, 0, 16'h3c57);
    @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    `CHK("reset", 26'h0, {resp_valid, resp_exception, resp_exc_code, resp_data})
    reset_n <= 1'b1;
    chk(0, 16'h6500, 1, 0, 0, 16'h3c57);
    stop_test;
  end
endmodule // tb_drive_status_register_access

// File: rtl/dsra_status_bank.v
// Read-only drive status register bank with 16/32-bit access decode
`timescale 1ns/1ps
`include "dsra_defines.vh"
// Function
// - Status parameters are read-only; writes to them are never accepted.
// - Model value: thousands/hundreds digits family, tens/units series, max 9999.
// - Main reference, run frequency, set frequency, third-fault frequency are 32-bit.
// - Word one bits 0-4: serial control, running, reverse, serial reference, reached.
// - Word one bit 5 fault present, bit 6 alarm present, bit 7 zero.
// - Word one bits 15-8 hold fault or alarm code, zero means none.
// - Word two bits 0-5 running type flags, bit 6 under-voltage.
// - Word two bit 7 and bits 8 upward are reserved, read zero.
// - Word three bits 1-0 reserved; bits 2-7 zero-speed through setting.
// - Word three bits 8-11 limiting, 12 fault, 13 speed, 14 torque, 15 position.
// - Start address bit 15 picks 32-bit access; bits 14-0 the parameter address.
// - In 32-bit access each parameter takes two consecutive 16-bit registers.
// - 32-bit access needs even register count; otherwise exception response.
// - Status words sit at 0x6500, 0x651f and 0x6528.
module dsra_status_bank #(
  parameter MAX_REGS = 16
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        serial_ctrl_en,
  input  wire        running,
  input  wire        reverse,
  input  wire        serial_ref_en,
  input  wire        main_set_reached,
  input  wire        fault_present,
  input  wire        alarm_present,
  input  wire [7:0]  event_code,
  input  wire [5:0]  run_type,
  input  wire        under_voltage,
  input  wire [5:0]  motion_phase,
  input  wire [3:0]  limiting,
  input  wire        drive_fault,
  input  wire [2:0]  control_mode,
  input  wire [3:0]  family_digits,
  input  wire [6:0]  series_digits,
  input  wire [31:0] main_ref_value,
  input  wire [31:0] run_freq_value,
  input  wire [31:0] set_freq_value,
  input  wire [31:0] fault3_freq_value,
  input  wire        req_valid,
  input  wire        req_write,
  input  wire [15:0] req_start,
  input  wire [15:0] req_count,
  input  wire [15:0] req_index,
  output reg         resp_valid,
  output reg         resp_exception,
  output reg  [7:0]  resp_exc_code,
  output reg  [15:0] resp_data
);

  reg  [15:0] drive_state_flags;
  reg  [15:0] running_type_flags;
  reg  [15:0] motion_phase_flags;
  reg  [13:0] model_value;
  reg  [15:0] next_state_word;
  reg  [15:0] next_type_word;
  reg  [15:0] next_phase_word;
  reg         next_exception;
  reg  [7:0]  next_exc_code;
  reg  [15:0] next_data;
  wire [13:0] family_part;
  wire [6:0]  series_clamped;
  wire [13:0] next_model;
  wire [13:0] model_clamped;
  wire        wide_mode;
  wire [14:0] param_base;
  wire [14:0] param_addr;
  wire [15:0] param_offset;
  wire        index_low;
  wire        wide_param;
  wire        count_zero;
  wire        count_over;
  wire        count_odd;
  wire        count_bad;
  wire        below_bank;
  wire        above_bank;
  wire        in_range;
  wire [31:0] param_value;

  // Family in thousands/hundreds, series in tens/units; clamped so the value never passes 9999
  assign family_part    = `DSRA_FAMILY_WEIGHT * {10'h000, family_digits};
  assign series_clamped = (series_digits > `DSRA_SERIES_MAX) ?
                          `DSRA_SERIES_MAX : series_digits;
  assign next_model     = family_part + {7'h00, series_clamped};
  assign model_clamped  = (next_model > `DSRA_MODEL_MAX) ?
                          `DSRA_MODEL_MAX : next_model;

  // Reserved bits start at zero and are never set
  always @* begin
    next_state_word                       = `DSRA_WORD_RESET;
    next_state_word[`DSRA_CTRL_BIT]       = serial_ctrl_en;
    next_state_word[`DSRA_RUN_BIT]        = running;
    next_state_word[`DSRA_REV_BIT]        = reverse;
    next_state_word[`DSRA_REF_BIT]        = serial_ref_en;
    next_state_word[`DSRA_REACHED_BIT]    = main_set_reached;
    next_state_word[`DSRA_FAULT_BIT]      = fault_present;
    next_state_word[`DSRA_ALARM_BIT]      = alarm_present;
    next_state_word[15:`DSRA_CODE_LSB]    = event_code;
  end

  always @* begin
    next_type_word                        = `DSRA_WORD_RESET;
    next_type_word[`DSRA_TYPE_LSB +: 6]   = run_type;
    next_type_word[`DSRA_UNDERV_BIT]      = under_voltage;
  end

  always @* begin
    next_phase_word                       = `DSRA_WORD_RESET;
    next_phase_word[`DSRA_PHASE_LSB +: 6] = motion_phase;
    next_phase_word[`DSRA_LIMIT_LSB +: 4] = limiting;
    next_phase_word[`DSRA_DFAULT_BIT]     = drive_fault;
    next_phase_word[`DSRA_MODE_LSB +: 3]  = control_mode;
  end

  // Status sampled each cycle; reading never disturbs it
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      drive_state_flags  <= `DSRA_WORD_RESET;
      running_type_flags <= `DSRA_WORD_RESET;
      motion_phase_flags <= `DSRA_WORD_RESET;
      model_value        <= `DSRA_MODEL_RESET;
    end else begin
      drive_state_flags  <= next_state_word;
      running_type_flags <= next_type_word;
      motion_phase_flags <= next_phase_word;
      model_value        <= model_clamped;
    end
  end

  // Decode: which parameters carry 32-bit values
  function is_wide_param;
    input [14:0] addr;
    begin
      is_wide_param = (addr == `DSRA_ADDR_MAIN_REF) || (addr == `DSRA_ADDR_RUN_FREQ) ||
                      (addr == `DSRA_ADDR_SET_FREQ) || (addr == `DSRA_ADDR_FAULT3_FREQ);
    end
  endfunction

  function [31:0] param_read;
    input [14:0] addr;
    begin
      case (addr)
        `DSRA_ADDR_STATE:       param_read = {16'h0000, drive_state_flags};
        `DSRA_ADDR_RUNTYPE:     param_read = {16'h0000, running_type_flags};
        `DSRA_ADDR_PHASE:       param_read = {16'h0000, motion_phase_flags};
        `DSRA_ADDR_MODEL:       param_read = {18'h00000, model_value};
        `DSRA_ADDR_MAIN_REF:    param_read = main_ref_value;
        `DSRA_ADDR_RUN_FREQ:    param_read = run_freq_value;
        `DSRA_ADDR_SET_FREQ:    param_read = set_freq_value;
        `DSRA_ADDR_FAULT3_FREQ: param_read = fault3_freq_value;
        default:                param_read = 32'h00000000;
      endcase
    end
  endfunction

  assign wide_mode    = req_start[`DSRA_WIDE_BIT];
  assign param_base   = req_start[14:0];
  // Two protocol registers per parameter when wide
  assign param_offset = wide_mode ? {1'b0, req_index[15:1]} : req_index;
  assign param_addr   = param_base + param_offset[14:0];
  assign index_low    = req_index[0];
  assign wide_param   = is_wide_param(param_addr);
  // A bad count is refused before any address check
  assign count_zero   = (req_count == 16'h0000);
  assign count_over   = (req_count > MAX_REGS[15:0]);
  assign count_odd    = wide_mode && req_count[0];
  assign count_bad    = count_zero || count_over || count_odd;
  assign below_bank   = (param_addr < `DSRA_ADDR_FIRST);
  assign above_bank   = (param_addr > `DSRA_ADDR_LAST);
  assign in_range     = !below_bank && !above_bank;
  assign param_value  = param_read(param_addr);

  // Priority write, then count, then address; writes never reach any state
  always @* begin
    next_exception = 1'b0;
    next_exc_code  = `DSRA_EXC_NONE;
    next_data      = `DSRA_WORD_RESET;
    if (req_write) begin
      next_exception = 1'b1;
      next_exc_code  = `DSRA_EXC_FUNC;
    end else if (count_bad) begin
      next_exception = 1'b1;
      next_exc_code  = `DSRA_EXC_VALUE;
    end else if (!in_range) begin
      next_exception = 1'b1;
      next_exc_code  = `DSRA_EXC_ADDR;
    end else if (wide_mode) begin
      // High half first; 16-bit values widen with zeros since status words are unsigned
      if (index_low) begin
        next_data = param_value[15:0];
      end else if (wide_param) begin
        next_data = param_value[31:16];
      end
    end else begin
      // Narrow access to a wide value returns its low half only
      next_data = param_value[15:0];
    end
  end

  // One answer per request, a cycle later; fields hold until the next request
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      resp_valid     <= 1'b0;
      resp_exception <= 1'b0;
      resp_exc_code  <= `DSRA_EXC_NONE;
      resp_data      <= `DSRA_WORD_RESET;
    end else begin
      resp_valid <= req_valid;
      if (req_valid) begin
        resp_exception <= next_exception;
        resp_exc_code  <= next_exc_code;
        resp_data      <= next_data;
      end
    end
  end

endmodule // dsra_status_bank

// File: shared/dsra_defines.vh
// Register addresses, field positions and codes of the drive status register bank
`ifndef DSRA_DEFINES_VH
`define DSRA_DEFINES_VH
`define DSRA_ADDR_STATE        15'h6500
`define DSRA_ADDR_MAIN_REF     15'h6501
`define DSRA_ADDR_MODEL        15'h6502
`define DSRA_ADDR_RUN_FREQ     15'h6505
`define DSRA_ADDR_SET_FREQ     15'h6515
`define DSRA_ADDR_RUNTYPE      15'h651f
`define DSRA_ADDR_FAULT3_FREQ  15'h6525
`define DSRA_ADDR_PHASE        15'h6528
`define DSRA_ADDR_FIRST        15'h6500
`define DSRA_ADDR_LAST         15'h6528
`define DSRA_WIDE_BIT          15
`define DSRA_CODE_LSB          8
`define DSRA_FAULT_BIT         5
`define DSRA_ALARM_BIT         6
`define DSRA_UNDERV_BIT        6
`define DSRA_CTRL_BIT          0
`define DSRA_RUN_BIT           1
`define DSRA_REV_BIT           2
`define DSRA_REF_BIT           3
`define DSRA_REACHED_BIT       4
`define DSRA_TYPE_LSB          0
`define DSRA_PHASE_LSB         2
`define DSRA_LIMIT_LSB         8
`define DSRA_DFAULT_BIT        12
`define DSRA_MODE_LSB          13
`define DSRA_FAMILY_WEIGHT     14'h0064
`define DSRA_SERIES_MAX        7'h63
`define DSRA_WORD_RESET        16'h0000
`define DSRA_MODEL_RESET       14'h0000
`define DSRA_MODEL_MAX         14'h270f
`define DSRA_EXC_NONE          8'h00
`define DSRA_EXC_FUNC          8'h01
`define DSRA_EXC_ADDR          8'h02
`define DSRA_EXC_VALUE         8'h03
`endif
